// ### verilog/hpg_pkg.sv
// package: pin map constants for host port and gpio function map
package hpg_pkg;
    localparam int HPG_NUM_GPIO = 32;
    // i2c slave address pair (8-bit form)
    localparam logic [7:0] HPG_I2C_WR_ADDR = 8'h36;
    localparam logic [7:0] HPG_I2C_RD_ADDR = 8'h37;
    // interior display pin positions
    localparam int HPG_PIN_LED_FB = 0;
    localparam int HPG_PIN_SEQ_START = 1;
    localparam int HPG_PIN_OPT_CMP = 2;
    localparam int HPG_PIN_SHUNT = 3;
    localparam int HPG_PIN_DRIVE = 4;
    localparam int HPG_PIN_WATCHDOG = 15;
    // host available pins in interior display configuration
    localparam logic [31:0] HPG_HOST_MASK_IDC = 32'h000001C0;
    // pins driven as fixed function outputs in interior display configuration
    localparam logic [31:0] HPG_FIXED_OUT_IDC = 32'h0000801A;
    // configurations
    typedef enum logic [1:0] {
        HPG_CFG_INTERIOR_DISPLAY,
        HPG_CFG_HEADLIGHT,
        HPG_CFG_OTHER
    } hpg_cfg_t;
    // port role
    typedef enum logic {
        HPG_ROLE_HOST_ON_SPI,
        HPG_ROLE_HOST_ON_I2C
    } hpg_role_t;
    localparam logic [15:0] HPG_PULSE_CNT_RST = 16'h0000;
endpackage : hpg_pkg

// ### verilog/hpg_port_if.sv
// interface: frame, pulse and count channel between top and pulse counter
`timescale 1ns/10ps
interface hpg_port_if;
    logic frame_start;
    logic pulse_n;
    logic [15:0] count;
    modport ctrl (output frame_start, output pulse_n, input count);
    modport cnt (input frame_start, input pulse_n, output count);
endinterface : hpg_port_if

// ### verilog/hpg_pulse_counter.sv
// module: counts active-low light pulses per frame
`timescale 1ns/10ps
module hpg_pulse_counter
    import hpg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    hpg_port_if.cnt bus
);
    logic prev_n;
    logic [15:0] run;
    logic [15:0] next_run;
    wire logic fall = prev_n & ~bus.pulse_n;
    // new frame restarts the count, a falling edge adds one
    assign next_run = bus.frame_start ? {15'h0000, fall}
                    : (fall ? run + 16'h0001 : run);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev_n <= 1'b1;
            run <= HPG_PULSE_CNT_RST;
            bus.count <= HPG_PULSE_CNT_RST;
        end else begin
            prev_n <= bus.pulse_n;
            run <= next_run;
            if (bus.frame_start) begin
                bus.count <= run;
            end
        end
    end
    pulse_count_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !bus.frame_start && !fall |=> run == $past(run))
        else $error("pulse count changed without edge");
endmodule : hpg_pulse_counter

// ### verilog/hpg_pin_map.sv
// module: host/diagnostic port routing and gpio function map
`timescale 1ns/10ps
module hpg_pin_map
    import hpg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    // straps
    input wire logic role_select,
    input wire logic [1:0] config_select,
    // spi slave command stream (already deframed)
    input wire logic spi_cmd_valid,
    input wire logic [7:0] spi_cmd_data,
    // i2c slave stream: start-address byte and data bytes
    input wire logic i2c_addr_valid,
    input wire logic [7:0] i2c_addr_byte,
    input wire logic i2c_data_valid,
    input wire logic [7:0] i2c_data_byte,
    input wire logic i2c_stop,
    output logic i2c_ack,
    output logic i2c_read_mode,
    // routed channels
    output logic host_cmd_valid,
    output logic [7:0] host_cmd_data,
    output logic diag_cmd_valid,
    output logic [7:0] diag_cmd_data,
    output logic host_on_i2c,
    // flash programming request from host channel
    output logic flash_prog_valid,
    output logic [7:0] flash_prog_data,
    // host gpio control
    input wire logic host_gpio_we,
    input wire logic [31:0] host_gpio_oe_req,
    input wire logic [31:0] host_gpio_out_req,
    output logic [31:0] host_gpio_in,
    // processor side functions
    input wire logic seq_start_req,
    input wire logic shunt_req,
    input wire logic drive_req,
    input wire logic watchdog_tick,
    input wire logic frame_start,
    output logic led_feedback,
    output logic [15:0] light_pulse_count,
    output logic config_is_interior,
    // gpio pads
    input wire logic [31:0] gpio_in,
    output logic [31:0] gpio_out,
    output logic [31:0] gpio_oe
);
    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    hpg_role_t role;
    hpg_cfg_t cfg;
    logic strap_taken;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strap_taken <= 1'b0;
            role <= HPG_ROLE_HOST_ON_SPI;
            cfg <= HPG_CFG_INTERIOR_DISPLAY;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            role <= hpg_role_t'(role_select);
            cfg <= (config_select == 2'b00) ? HPG_CFG_INTERIOR_DISPLAY
                 : (config_select == 2'b01) ? HPG_CFG_HEADLIGHT
                 : HPG_CFG_OTHER;
        end
    end
    // no configuration function drives until the straps are taken
    wire logic is_idc = strap_taken & (cfg == HPG_CFG_INTERIOR_DISPLAY);

    // ------------------------------------------------------------
    // i2c address match
    // ------------------------------------------------------------
    logic i2c_sel;
    wire logic addr_wr = i2c_addr_byte == HPG_I2C_WR_ADDR;
    wire logic addr_rd = i2c_addr_byte == HPG_I2C_RD_ADDR;
    wire logic addr_hit = i2c_addr_valid & (addr_wr | addr_rd);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            i2c_sel <= 1'b0;
            i2c_ack <= 1'b0;
            i2c_read_mode <= 1'b0;
        end else begin
            i2c_ack <= addr_hit;
            if (i2c_addr_valid) begin
                i2c_sel <= addr_hit;
                i2c_read_mode <= addr_rd;
            end else if (i2c_stop) begin
                i2c_sel <= 1'b0;
            end
        end
    end
    wire logic i2c_wr_valid = i2c_data_valid & i2c_sel & ~i2c_read_mode;

    // ------------------------------------------------------------
    // port role routing
    // ------------------------------------------------------------
    wire logic host_i2c = (role == HPG_ROLE_HOST_ON_I2C);
    wire logic next_host_valid = host_i2c ? i2c_wr_valid : spi_cmd_valid;
    wire logic [7:0] next_host_data = host_i2c ? i2c_data_byte
                                               : spi_cmd_data;
    wire logic next_diag_valid = host_i2c ? spi_cmd_valid : i2c_wr_valid;
    wire logic [7:0] next_diag_data = host_i2c ? spi_cmd_data
                                               : i2c_data_byte;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            host_cmd_valid <= 1'b0;
            host_cmd_data <= 8'h00;
            diag_cmd_valid <= 1'b0;
            diag_cmd_data <= 8'h00;
            flash_prog_valid <= 1'b0;
            flash_prog_data <= 8'h00;
            host_on_i2c <= 1'b0;
        end else begin
            host_on_i2c <= host_i2c;
            host_cmd_valid <= next_host_valid;
            host_cmd_data <= next_host_data;
            diag_cmd_valid <= next_diag_valid;
            diag_cmd_data <= next_diag_data;
            flash_prog_valid <= next_host_valid;
            flash_prog_data <= next_host_data;
        end
    end

    // ------------------------------------------------------------
    // host gpio shadow
    // ------------------------------------------------------------
    logic [31:0] host_oe;
    logic [31:0] host_out;
    wire logic [31:0] host_mask = is_idc ? HPG_HOST_MASK_IDC : 32'h00000000;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            host_oe <= 32'h00000000;
            host_out <= 32'h00000000;
        end else if (host_gpio_we) begin
            host_oe <= host_gpio_oe_req & host_mask;
            host_out <= host_gpio_out_req & host_mask;
        end
    end

    // ------------------------------------------------------------
    // fixed function mapping
    // ------------------------------------------------------------
    logic [31:0] fixed_out;
    always_comb begin
        fixed_out = 32'h00000000;
        fixed_out[HPG_PIN_SEQ_START] = seq_start_req;
        fixed_out[HPG_PIN_SHUNT] = shunt_req;
        fixed_out[HPG_PIN_DRIVE] = drive_req;
        fixed_out[HPG_PIN_WATCHDOG] = watchdog_tick;
    end
    wire logic [31:0] fixed_oe = is_idc ? HPG_FIXED_OUT_IDC : 32'h00000000;
    // reserved and input pins get neither mask, so stay undriven
    wire logic [31:0] next_oe = fixed_oe | (host_oe & host_mask);
    wire logic [31:0] next_out = (fixed_out & fixed_oe)
                               | (host_out & host_mask);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gpio_oe <= 32'h00000000;
            gpio_out <= 32'h00000000;
            host_gpio_in <= 32'h00000000;
            led_feedback <= 1'b0;
            config_is_interior <= 1'b0;
        end else begin
            gpio_oe <= next_oe;
            gpio_out <= next_out;
            host_gpio_in <= gpio_in & host_mask;
            led_feedback <= is_idc & gpio_in[HPG_PIN_LED_FB];
            config_is_interior <= is_idc;
        end
    end

    // ------------------------------------------------------------
    // light pulse counting
    // ------------------------------------------------------------
    hpg_port_if pc_bus ();
    assign pc_bus.frame_start = frame_start;
    assign pc_bus.pulse_n = is_idc ? gpio_in[HPG_PIN_OPT_CMP] : 1'b1;
    hpg_pulse_counter hpg_pulse_counter_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .bus(pc_bus)
    );
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            light_pulse_count <= HPG_PULSE_CNT_RST;
        end else begin
            light_pulse_count <= pc_bus.count;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    strap_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        strap_taken |=> role == $past(role) && cfg == $past(cfg))
        else $error("strap changed after capture");
    strap_first_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $fell(rst) |=> gpio_oe == 32'h00000000 && !config_is_interior
        && !host_on_i2c)
        else $error("pins driven before strap capture");
    role_route_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        strap_taken && !host_i2c && spi_cmd_valid
        |=> host_cmd_valid && host_cmd_data == $past(spi_cmd_data))
        else $error("spi command not routed to host");
    diag_spi_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        strap_taken && host_i2c && spi_cmd_valid
        |=> diag_cmd_valid && diag_cmd_data == $past(spi_cmd_data))
        else $error("spi command not routed to diagnostic port");
    diag_i2c_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        strap_taken && !host_i2c && i2c_wr_valid
        |=> diag_cmd_valid && diag_cmd_data == $past(i2c_data_byte))
        else $error("i2c byte not routed to diagnostic port");
    route_idle_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        strap_taken && !spi_cmd_valid && !i2c_wr_valid
        |=> !host_cmd_valid && !diag_cmd_valid)
        else $error("routed byte without a source byte");
    i2c_addr_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        i2c_addr_valid && i2c_addr_byte == HPG_I2C_WR_ADDR
        |=> i2c_ack && !i2c_read_mode)
        else $error("i2c write address not acked");
    i2c_read_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        i2c_addr_valid && i2c_addr_byte == HPG_I2C_RD_ADDR
        |=> i2c_ack && i2c_read_mode)
        else $error("i2c read address not acked");
    i2c_other_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        i2c_addr_valid && i2c_addr_byte != HPG_I2C_WR_ADDR
        && i2c_addr_byte != HPG_I2C_RD_ADDR |=> !i2c_ack)
        else $error("foreign i2c address acked");
    flash_path_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        strap_taken && host_i2c && i2c_wr_valid
        |=> flash_prog_valid && flash_prog_data == $past(i2c_data_byte))
        else $error("i2c host byte missing on flash path");
    flash_diag_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        strap_taken && !host_i2c && !spi_cmd_valid |=> !flash_prog_valid)
        else $error("diagnostic byte reached flash path");

    // ------------------------------------------------------------
    // pin map checks
    // ------------------------------------------------------------
    reserved_in_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (gpio_oe & ~(HPG_FIXED_OUT_IDC | HPG_HOST_MASK_IDC)) == 32'h00000000)
        else $error("reserved pin driven");
    host_pin_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        strap_taken && is_idc && host_gpio_we |=> ##1
        (gpio_oe & HPG_HOST_MASK_IDC)
        == ($past(host_gpio_oe_req, 2) & HPG_HOST_MASK_IDC)
        && (gpio_out & HPG_HOST_MASK_IDC)
        == ($past(host_gpio_out_req, 2) & HPG_HOST_MASK_IDC))
        else $error("host pin not following host write");
    cfg_other_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        strap_taken && !is_idc |=> gpio_oe == 32'h00000000
        && !led_feedback && host_gpio_in == 32'h00000000)
        else $error("pins active outside interior configuration");
    watchdog_out_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        strap_taken && is_idc |=> gpio_oe[HPG_PIN_WATCHDOG]
        && gpio_out[HPG_PIN_WATCHDOG] == $past(watchdog_tick))
        else $error("watchdog pin not following tick");
    drive_out_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        is_idc |=> gpio_out[HPG_PIN_DRIVE] == $past(drive_req)
        && gpio_out[HPG_PIN_SHUNT] == $past(shunt_req)
        && gpio_out[HPG_PIN_SEQ_START] == $past(seq_start_req))
        else $error("led control pin mismatch");
    fb_in_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        is_idc |=> !gpio_oe[HPG_PIN_LED_FB] && !gpio_oe[HPG_PIN_OPT_CMP]
        && led_feedback == $past(gpio_in[HPG_PIN_LED_FB]))
        else $error("feedback pin handling wrong");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    cov_i2c_host_c: cover property (@(posedge sys_clk)
        host_i2c && i2c_wr_valid ##1 host_cmd_valid);
    cov_host_gpio_c: cover property (@(posedge sys_clk)
        host_gpio_we && host_gpio_oe_req[7] ##2 gpio_oe[7]);
    cov_i2c_read_c: cover property (@(posedge sys_clk)
        i2c_addr_valid && addr_rd);
    cov_frame_c: cover property (@(posedge sys_clk)
        frame_start ##2 light_pulse_count != HPG_PULSE_CNT_RST);
    cov_cfg_other_c: cover property (@(posedge sys_clk)
        strap_taken && !is_idc);
endmodule : hpg_pin_map

// ### testbench/hpg_far_side.sv
// far side model: illumination controller pads and watchdog monitor
`timescale 1ns/10ps
module hpg_far_side #(
    parameter int WD_LIMIT = 40
) (
    input wire logic sys_clk,
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    input wire logic opt_n,
    input wire logic [31:0] ext_drive,
    output logic [31:0] pad_in,
    output logic wd_fault
);
    logic [31:0] ext_level;
    logic wd_last = 1'h0;
    int wd_idle = 0;
    // undriven pads fall to their pull-downs unless something drives them
    always_comb begin
        ext_level = ext_drive;
        ext_level[0] = pad_oe[4] & pad_out[4];
        ext_level[2] = opt_n;
        pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
    end
    // fault once the watchdog line has stood still too long
    always @(posedge sys_clk) begin
        wd_last <= pad_out[15];
        wd_idle <= (pad_out[15] !== wd_last) ? 0 : wd_idle + 1;
        wd_fault <= (wd_idle > WD_LIMIT);
    end
endmodule : hpg_far_side

// ### testbench/host_port_and_gpio_function_map_tb.sv
// self-checking bench for the host port and gpio function map
`timescale 1ns/10ps
module host_port_and_gpio_function_map_tb;
    import hpg_pkg::*;
    logic sys_clk = 1'h0, rst = 1'h1, role_select = 1'h0, opt_n = 1'h1;
    logic spi_cmd_valid = 1'h0, i2c_addr_valid = 1'h0, i2c_stop = 1'h0;
    logic i2c_data_valid = 1'h0, host_gpio_we = 1'h0, frame_start = 1'h0;
    logic seq_start_req = 1'h0, shunt_req = 1'h0, drive_req = 1'h0;
    logic watchdog_tick = 1'h0, wd_fault;
    logic [1:0] config_select = 2'h0;
    logic [7:0] spi_cmd_data = 8'h0, i2c_addr_byte = 8'h0;
    logic [7:0] i2c_data_byte = 8'h0;
    logic [31:0] host_gpio_oe_req = 32'h0, host_gpio_out_req = 32'h0;
    logic [31:0] ext_drive = 32'h0, host_gpio_in, gpio_in, gpio_out, gpio_oe;
    logic i2c_ack, i2c_read_mode, host_cmd_valid, diag_cmd_valid;
    logic host_on_i2c, flash_prog_valid, led_feedback, config_is_interior;
    logic [7:0] host_cmd_data, diag_cmd_data, flash_prog_data;
    logic [15:0] light_pulse_count;
    int errors = 0, num_checks = 0;
    int pins[4] = '{HPG_PIN_SEQ_START, HPG_PIN_SHUNT, HPG_PIN_DRIVE,
        HPG_PIN_WATCHDOG};

    always #5 sys_clk = ~sys_clk;

    hpg_pin_map hpg_pin_map_inst (.sys_clk, .rst, .role_select,
        .config_select, .spi_cmd_valid, .spi_cmd_data, .i2c_addr_valid,
        .i2c_addr_byte, .i2c_data_valid, .i2c_data_byte, .i2c_stop, .i2c_ack,
        .i2c_read_mode, .host_cmd_valid, .host_cmd_data, .diag_cmd_valid,
        .diag_cmd_data, .host_on_i2c, .flash_prog_valid, .flash_prog_data,
        .host_gpio_we, .host_gpio_oe_req, .host_gpio_out_req, .host_gpio_in,
        .seq_start_req, .shunt_req, .drive_req, .watchdog_tick, .frame_start,
        .led_feedback, .light_pulse_count, .config_is_interior, .gpio_in,
        .gpio_out, .gpio_oe);
    hpg_far_side hpg_far_side_inst (.sys_clk, .pad_out(gpio_out),
        .pad_oe(gpio_oe), .opt_n, .ext_drive, .pad_in(gpio_in), .wd_fault);

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic start(input logic role, input logic [1:0] cfg);
        rst = 1'h1;
        role_select = role;
        config_select = cfg;
        tick(12);
        rst = 1'h0;
        tick(1);
        chk(gpio_oe, 32'h0);
        // straps wiggle after capture and must be ignored
        role_select = ~role;
        config_select = ~cfg;
        tick(2);
    endtask : start
    task automatic spi_byte(input logic [7:0] d);
        spi_cmd_valid = 1'h1;
        spi_cmd_data = d;
        tick(1);
        spi_cmd_valid = 1'h0;
    endtask : spi_byte
    task automatic i2c_xfer(input logic [7:0] a, d, input logic ack);
        i2c_addr_valid = 1'h1;
        i2c_addr_byte = a;
        tick(1);
        i2c_addr_valid = 1'h0;
        chk(i2c_ack, ack);
        i2c_data_valid = 1'h1;
        i2c_data_byte = d;
        tick(1);
        i2c_data_valid = 1'h0;
    endtask : i2c_xfer
    task automatic i2c_end(input string name);
        i2c_stop = 1'h1;
        tick(1);
        i2c_stop = 1'h0;
        $display("test %s done", name);
    endtask : i2c_end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #20000;
        errors++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        start(1'h0, 2'h0);
        chk({host_on_i2c, config_is_interior}, 2'h1);
        spi_byte(8'hA5);
        chk({host_cmd_valid, host_cmd_data, diag_cmd_valid}, 10'h34A);
        chk({flash_prog_valid, flash_prog_data}, 9'h1A5);
        i2c_xfer(8'h36, 8'h5A, 1'h1);
        chk({diag_cmd_valid, diag_cmd_data, host_cmd_valid}, 10'h2B4);
        chk(flash_prog_valid, 1'h0);
        i2c_end("host on spi");
        i2c_xfer(8'h37, 8'h00, 1'h1);
        chk(i2c_read_mode, 1'h1);
        i2c_end("read address");
        i2c_xfer(8'h38, 8'h5A, 1'h0);
        chk(diag_cmd_valid, 1'h0);
        i2c_end("foreign address");
        start(1'h1, 2'h0);
        chk(host_on_i2c, 1'h1);
        i2c_xfer(8'h36, 8'hC3, 1'h1);
        chk({host_cmd_valid, host_cmd_data, flash_prog_valid}, 10'h387);
        spi_byte(8'h3C);
        chk({diag_cmd_valid, diag_cmd_data, host_cmd_valid}, 10'h278);
        i2c_end("host on i2c");
        ext_drive = 32'h0000_0140;
        tick(3);
        chk(host_gpio_in, 32'h0000_0140);
        chk(gpio_oe, HPG_FIXED_OUT_IDC);
        for (int i = 0; i < 4; i++) begin
            {watchdog_tick, drive_req, shunt_req, seq_start_req} = 4'h1 << i;
            tick(3);
            chk(gpio_out & HPG_FIXED_OUT_IDC, 32'h1 << pins[i]);
            chk(led_feedback, i == 2);
        end
        host_gpio_oe_req = 32'hFFFF_FFFF;
        host_gpio_out_req = 32'hFFFF_FF7F;
        host_gpio_we = 1'h1;
        tick(1);
        host_gpio_we = 1'h0;
        tick(3);
        chk(gpio_oe, HPG_FIXED_OUT_IDC | HPG_HOST_MASK_IDC);
        chk(gpio_out & HPG_HOST_MASK_IDC, 32'h0000_0140);
        $display("test gpio map done");
        for (int n = 3; n > 0; n -= 2) begin
            repeat (n) begin
                opt_n = 1'h0;
                tick(2);
                opt_n = 1'h1;
                tick(2);
            end
            frame_start = 1'h1;
            tick(1);
            frame_start = 1'h0;
            tick(2);
            chk(light_pulse_count, n);
        end
        repeat (10) begin
            watchdog_tick = ~watchdog_tick;
            tick(8);
        end
        chk(wd_fault, 1'h0);
        tick(60);
        chk(wd_fault, 1'h1);
        $display("test pulses done");
        for (int c = 1; c < 4; c++) begin
            start(c[0], 2'(c));
            host_gpio_we = 1'h1;
            tick(1);
            host_gpio_we = 1'h0;
            drive_req = 1'h1;
            tick(3);
            chk(config_is_interior, 1'h0);
            chk(host_on_i2c, c[0]);
            chk(gpio_oe, 32'h0);
            chk(gpio_out, 32'h0);
            chk(host_gpio_in, 32'h0);
            drive_req = 1'h0;
        end
        $display("test other configurations done");
        report_and_stop();
    end
endmodule : host_port_and_gpio_function_map_tb
